/* File: hw/uil_top.sv */
// user input decision logic, output relay forcing and register slave
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - closed-XOR-virtual-off: asserts when exactly one of closed, virtual-off holds
// - open-XOR-virtual-on: asserts for open/off and closed/on, else deasserts
// - open-XOR-virtual-off: asserts for open/on and closed/off, else deasserts
// - alarm: message, aux LED and relay while asserted, event logged
// - control acts as alarm but without message or alarm LED
// - trip: trip relay and LED join aux relay and LED
// - trip message and LED stay latched until a reset clears them
// - virtual inputs 15 to 20 use the virtual-on/off logic alone
// - forcing all relays de-energised holds every relay off
// - forcing relay 1 energised drives trip output and trip LED
// - each relay 1 to 8 has its own force setting; 8 is health
// - forced solid-state output follows its own force setting
// - closed-XOR-virtual-on: asserts for closed/off and open/on only
// - closed-OR-virtual-on: asserts when closed or virtual on
// - open-AND-virtual-off: asserts only when open and virtual off
module uil_top (
	// clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// register bus write
	input  wire logic [7:0]        awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	// register bus read
	input  wire logic [7:0]        araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [31:0]       rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	// field side
	input  wire logic [13:0]       contact_in,
	input  wire logic              reset_key_in,
	output var  uil_pkg::uil_out_type outs,
	output var  logic [19:0]       diag_msg,
	output var  logic              irq
);
	// ==========================================================
	// state
	uil_pkg::uil_cfg_type cfg_reg [uil_pkg::NUM_INPUT];
	logic [19:0] virt_reg;
	logic [9:0]  force_reg;
	logic        close_cmd_reg;
	logic [19:0] status_reg;
	logic [19:0] mask_reg;
	logic [19:0] asserted_reg;
	logic [19:0] asserted_next;
	logic [19:0] trip_latch_reg;
	logic        key_d_reg;
	logic [14:0] sync_q;
	logic [13:0] contact_q;
	logic        key_q;
	logic [19:0] is_alarm;
	logic [19:0] is_trip;
	logic [19:0] is_active;
	logic [4:0]  aux_req;
	logic        clear_pulse;
	logic        aw_h_reg;
	logic        w_h_reg;
	logic [7:0]  awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        do_wr;
	logic        rd_take;
	logic [31:0] wr_merged;
	uil_pkg::uil_out_type outs_next;

	// ==========================================================
	// decode helpers
	function automatic logic cfg_hit(input logic [7:0] a);
		cfg_hit = (a[7:2] >= uil_pkg::ADDR_CFG_BASE[7:2]) &&
			(a[7:2] < uil_pkg::ADDR_CFG_BASE[7:2] + 6'(uil_pkg::NUM_INPUT));
	endfunction

	function automatic logic [4:0] cfg_idx(input logic [7:0] a);
		logic [5:0] d;
		d = a[7:2] - uil_pkg::ADDR_CFG_BASE[7:2];
		cfg_idx = d[4:0];
	endfunction

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = cfg_hit(a) || (a[7:5] == 3'h0);
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] a);
		reg_read = 32'h0;
		unique case ({a[7:2], 2'h0})
			uil_pkg::ADDR_CTRL:     reg_read = {30'h0, close_cmd_reg, 1'b0};
			uil_pkg::ADDR_VIRT:     reg_read = {12'h0, virt_reg};
			uil_pkg::ADDR_FORCE:    reg_read = {22'h0, force_reg};
			uil_pkg::ADDR_STATUS:   reg_read = {12'h0, status_reg};
			uil_pkg::ADDR_MASK:     reg_read = {12'h0, mask_reg};
			uil_pkg::ADDR_ASSERTED: reg_read = {12'h0, asserted_reg};
			uil_pkg::ADDR_TRIPLAT:  reg_read = {12'h0, trip_latch_reg};
			uil_pkg::ADDR_OUTPUTS:  reg_read = {20'h0, outs};
			default: begin
				if (cfg_hit(a)) begin
					reg_read = {23'h0, cfg_reg[cfg_idx(a)]};
				end
			end
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (nv & m);
	endfunction

	// ==========================================================
	// bus slave: one write and one read in flight
	assign awready = !aw_h_reg && !bvalid;
	assign wready  = !w_h_reg && !bvalid;
	assign do_wr   = aw_h_reg && w_h_reg && !bvalid;
	assign arready = !rvalid;
	assign rd_take = arvalid && arready;
	assign wr_merged = merge(reg_read(awaddr_reg), wdata_reg, wstrb_reg);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h_reg   <= 1'b0;
			w_h_reg    <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg  <= 32'h0;
			wstrb_reg  <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_h_reg   <= 1'b1;
				awaddr_reg <= awaddr;
			end else if (do_wr) begin
				aw_h_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				w_h_reg   <= 1'b1;
				wdata_reg <= wdata;
				wstrb_reg <= wstrb;
			end else if (do_wr) begin
				w_h_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= uil_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid <= 1'b1;
			bresp  <= reg_known(awaddr_reg) ? uil_pkg::RESP_OKAY : uil_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= uil_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rdata  <= reg_read(araddr);
			rresp  <= reg_known(araddr) ? uil_pkg::RESP_OKAY : uil_pkg::RESP_SLVERR;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// software settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			virt_reg      <= 20'h0;
			force_reg     <= uil_pkg::FORCE_RESET;
			close_cmd_reg <= 1'b0;
			mask_reg      <= 20'h0;
		end else if (do_wr) begin
			unique case ({awaddr_reg[7:2], 2'h0})
				uil_pkg::ADDR_VIRT:  virt_reg <= wr_merged[19:0];
				uil_pkg::ADDR_FORCE: force_reg <= wr_merged[9:0];
				uil_pkg::ADDR_MASK:  mask_reg <= wr_merged[19:0];
				uil_pkg::ADDR_CTRL:  close_cmd_reg <= wr_merged[uil_pkg::CTRL_CLOSE_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < uil_pkg::NUM_INPUT; i++) begin
				cfg_reg[i] <= uil_pkg::CFG_RESET;
			end
		end else if (do_wr && cfg_hit(awaddr_reg)) begin
			cfg_reg[cfg_idx(awaddr_reg)] <= uil_pkg::uil_cfg_type'(wr_merged[8:0]);
		end
	end

	// ==========================================================
	// field inputs and user input evaluation
	uil_sync #(
		.WIDTH(uil_pkg::SYNC_WIDTH)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.raw_in   ({reset_key_in, contact_in}),
		.clean_out(sync_q)
	);
	assign contact_q = sync_q[13:0];
	assign key_q     = sync_q[14];

	for (genvar i = 0; i < uil_pkg::NUM_INPUT; i++) begin : g_in
		if (i < uil_pkg::NUM_CONTACT) begin : g_contact
			assign asserted_next[i] = uil_pkg::eval_input(cfg_reg[i].mode,
				contact_q[i], virt_reg[i], 1'b0);
		end else begin : g_virt
			assign asserted_next[i] = uil_pkg::eval_input(cfg_reg[i].mode,
				1'b0, virt_reg[i], 1'b1);
		end
		assign is_alarm[i]  = asserted_reg[i] && (cfg_reg[i].func == uil_pkg::FN_ALARM);
		assign is_trip[i]   = asserted_reg[i] && (cfg_reg[i].func == uil_pkg::FN_TRIP);
		assign is_active[i] = asserted_reg[i] && (cfg_reg[i].func != uil_pkg::FN_DISABLED);
	end

	always_comb begin
		aux_req = 5'h0;
		for (int i = 0; i < uil_pkg::NUM_INPUT; i++) begin
			if (is_active[i] && cfg_reg[i].aux_sel < 3'(uil_pkg::NUM_AUX)) begin
				aux_req[cfg_reg[i].aux_sel] = 1'b1;
			end
		end
	end

	// front-panel key and software both count as a reset of the latches
	assign clear_pulse = (key_q && !key_d_reg) || (do_wr &&
		({awaddr_reg[7:2], 2'h0} == uil_pkg::ADDR_CTRL) && wr_merged[uil_pkg::CTRL_CLEAR_BIT]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			asserted_reg <= 20'h0;
			key_d_reg    <= 1'b0;
		end else begin
			asserted_reg <= asserted_next;
			key_d_reg    <= key_q;
		end
	end

	// a trip still asserted in the clearing cycle stays latched
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_latch_reg <= 20'h0;
		end else begin
			trip_latch_reg <= (trip_latch_reg & ~{20{clear_pulse}}) | is_trip;
		end
	end

	// ==========================================================
	// events: rising assertion is logged, read of status clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			status_reg <= 20'h0;
			irq        <= 1'b0;
		end else begin
			status_reg <= (status_reg & ~((rd_take && {araddr[7:2], 2'h0} ==
				uil_pkg::ADDR_STATUS) ? status_reg : 20'h0)) |
				(asserted_next & ~asserted_reg);
			irq <= |(status_reg & mask_reg);
		end
	end

	// ==========================================================
	// outputs: normal logic, overridden by the test force settings
	always_comb begin
		outs_next.relay = 8'h0;
		outs_next.relay[uil_pkg::RELAY_TRIP]  = |is_trip;
		outs_next.relay[uil_pkg::RELAY_CLOSE] = close_cmd_reg;
		outs_next.relay[uil_pkg::RELAY_AUX_FIRST +: uil_pkg::NUM_AUX] = aux_req;
		outs_next.relay[uil_pkg::RELAY_HEALTH] = 1'b1;
		outs_next.ssr_on    = |is_trip;
		outs_next.aux_led   = |is_active;
		outs_next.alarm_led = |is_alarm;
		outs_next.trip_led  = |(trip_latch_reg | is_trip);
		if (force_reg[uil_pkg::FORCE_EN_BIT]) begin
			outs_next.relay  = force_reg[uil_pkg::FORCE_RELAY_LSB +: uil_pkg::NUM_RELAY];
			outs_next.ssr_on = force_reg[uil_pkg::FORCE_SSR_BIT];
			if (force_reg[uil_pkg::FORCE_RELAY_LSB]) begin
				outs_next.trip_led = 1'b1;
			end
		end
	end

	// relays leave force the cycle after it is disabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			outs     <= '0;
			diag_msg <= 20'h0;
		end else begin
			outs     <= outs_next;
			diag_msg <= is_alarm | trip_latch_reg | is_trip;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_xor_closed_voff: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_CX_VOFF |=>
		asserted_reg[0] == ($past(contact_q[0]) ^ !$past(virt_reg[0])))
		else $error("closed xor voff mismatch");
	a_xor_open_von: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_OX_VON && !contact_q[0] && !virt_reg[0]
		|=> asserted_reg[0])
		else $error("open xor von not asserted");
	a_xor_open_voff: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_OX_VOFF |=>
		asserted_reg[0] == ($past(contact_q[0]) ^ $past(virt_reg[0])))
		else $error("open xor voff mismatch");
	a_alarm_outputs: assert property (
		asserted_reg[0] && cfg_reg[0].func == uil_pkg::FN_ALARM
		|=> diag_msg[0] && outs.alarm_led && outs.aux_led)
		else $error("alarm outputs missing");
	a_control_quiet: assert property (
		asserted_reg == 20'h1 && cfg_reg[0].func == uil_pkg::FN_CONTROL &&
		trip_latch_reg == 20'h0 |=> !diag_msg[0] && !outs.alarm_led && outs.aux_led)
		else $error("control lit alarm");
	a_trip_relay: assert property (
		is_trip[0] && !force_reg[uil_pkg::FORCE_EN_BIT]
		|=> outs.relay[uil_pkg::RELAY_TRIP] && outs.trip_led && outs.aux_led)
		else $error("trip relay not driven");
	a_trip_latched: assert property (
		trip_latch_reg[0] && !clear_pulse |=> trip_latch_reg[0] ##1 diag_msg[0])
		else $error("trip latch lost");
	a_virt_only: assert property (
		cfg_reg[14].mode[3:2] != 2'h3 |=> asserted_reg[14] == ($past(virt_reg[14]) ^ $past(cfg_reg[14].mode[0])))
		else $error("virtual input mismatch");
	a_force_all_off: assert property (
		force_reg == 10'h001 |=> outs.relay == 8'h00 && !outs.ssr_on)
		else $error("forced relays not off");
	a_force_trip: assert property (
		force_reg[uil_pkg::FORCE_EN_BIT] && force_reg[uil_pkg::FORCE_RELAY_LSB]
		|=> outs.relay[uil_pkg::RELAY_TRIP] && outs.trip_led)
		else $error("forced trip not shown");
	a_force_each: assert property (
		force_reg[uil_pkg::FORCE_EN_BIT] |=>
		outs.relay == $past(force_reg[uil_pkg::FORCE_RELAY_LSB +: uil_pkg::NUM_RELAY]))
		else $error("relay force mismatch");
	a_force_ssr: assert property (
		force_reg[uil_pkg::FORCE_EN_BIT] |=> outs.ssr_on == $past(force_reg[uil_pkg::FORCE_SSR_BIT]))
		else $error("solid state force mismatch");
	a_normal_control: assert property (
		!force_reg[uil_pkg::FORCE_EN_BIT] |=> outs.relay[uil_pkg::RELAY_HEALTH] &&
		outs.relay[uil_pkg::RELAY_CLOSE] == $past(close_cmd_reg) && outs.ssr_on == $past(|is_trip))
		else $error("normal control not restored");
	a_xor_closed_von: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_CX_VON |=>
		asserted_reg[0] == ($past(contact_q[0]) ^ $past(virt_reg[0])))
		else $error("closed xor von mismatch");
	a_or_closed_von: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_COR_VON |=>
		asserted_reg[0] == ($past(contact_q[0]) || $past(virt_reg[0])))
		else $error("closed or von mismatch");
	a_and_open_voff: assert property (
		cfg_reg[0].mode == uil_pkg::MODE_OAND_VOFF |=>
		asserted_reg[0] == (!$past(contact_q[0]) && !$past(virt_reg[0])))
		else $error("open and voff mismatch");
endmodule
`default_nettype wire

/* File: hw/uil_pkg.sv */
// shared constants, types and input evaluation for the user input logic block
package uil_pkg;

	// ==========================================================
	// sizes
	localparam int NUM_CONTACT = 14;
	localparam int NUM_INPUT   = 20;
	localparam int NUM_RELAY   = 8;
	localparam int NUM_AUX     = 5;
	localparam int SYNC_WIDTH  = NUM_CONTACT + 1;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_VIRT     = 8'h04;
	localparam logic [7:0] ADDR_FORCE    = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0c;
	localparam logic [7:0] ADDR_MASK     = 8'h10;
	localparam logic [7:0] ADDR_ASSERTED = 8'h14;
	localparam logic [7:0] ADDR_TRIPLAT  = 8'h18;
	localparam logic [7:0] ADDR_OUTPUTS  = 8'h1c;
	localparam logic [7:0] ADDR_CFG_BASE = 8'h40;

	// ==========================================================
	// field positions and reset values
	localparam int CTRL_CLEAR_BIT  = 0;
	localparam int CTRL_CLOSE_BIT  = 1;
	localparam int FORCE_EN_BIT    = 0;
	localparam int FORCE_RELAY_LSB = 1;
	localparam int FORCE_SSR_BIT   = 9;
	localparam int RELAY_TRIP      = 0;
	localparam int RELAY_CLOSE     = 1;
	localparam int RELAY_AUX_FIRST = 2;
	localparam int RELAY_HEALTH    = 7;
	localparam logic [3:0] MODE_RESET  = 4'hc;
	localparam logic [9:0] FORCE_RESET = 10'h000;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// assertion mode: [3:2] combine, [1] contact open sense, [0] virtual off sense
	localparam logic [1:0] OP_AND = 2'h0;
	localparam logic [1:0] OP_OR  = 2'h1;
	localparam logic [1:0] OP_XOR = 2'h2;
	localparam logic [3:0] MODE_CX_VON   = 4'h8;
	localparam logic [3:0] MODE_CX_VOFF  = 4'h9;
	localparam logic [3:0] MODE_OX_VON   = 4'ha;
	localparam logic [3:0] MODE_OX_VOFF  = 4'hb;
	localparam logic [3:0] MODE_COR_VON  = 4'h4;
	localparam logic [3:0] MODE_OAND_VOFF = 4'h3;

	typedef enum logic [1:0] {FN_DISABLED, FN_ALARM, FN_CONTROL, FN_TRIP} uil_func_type;

	typedef struct packed {
		logic [2:0]   aux_sel;
		uil_func_type func;
		logic [3:0]   mode;
	} uil_cfg_type;

	typedef struct packed {
		logic       trip_led;
		logic       alarm_led;
		logic       aux_led;
		logic       ssr_on;
		logic [7:0] relay;
	} uil_out_type;

	localparam uil_cfg_type CFG_RESET = '{aux_sel: 3'h0, func: FN_DISABLED, mode: MODE_RESET};

	// virtual-only inputs have no contact, so only the virtual term counts
	function automatic logic eval_input(input logic [3:0] mode, input logic closed,
		input logic von, input logic virt_only);
		logic c;
		logic v;
		c = closed ^ mode[1];
		v = von ^ mode[0];
		if (virt_only) begin
			eval_input = (mode[3:2] != 2'h3) && v;
		end else begin
			unique case (mode[3:2])
				OP_AND:  eval_input = c & v;
				OP_OR:   eval_input = c | v;
				OP_XOR:  eval_input = c ^ v;
				default: eval_input = 1'b0;
			endcase
		end
	endfunction

endpackage

/* File: hw/uil_sync.sv */
// three-stage input synchroniser that follows a change once two late stages agree
`timescale 1ns/10ps
`default_nettype none
module uil_sync #(
	parameter int WIDTH = uil_pkg::SYNC_WIDTH
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	// raw and clean levels
	input  wire logic [WIDTH-1:0] raw_in,
	output var  logic [WIDTH-1:0] clean_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a bit that still disagrees keeps its old clean level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clean_out <= '0;
		end else begin
			clean_out <= (s2_reg & s3_reg) | (clean_out & (s2_reg ^ s3_reg));
		end
	end
endmodule
`default_nettype wire

/* File: sim/uil_field_model.sv */
// field-side model: contact wiring and front-panel reset key
`timescale 1ns/10ps
`default_nettype none
module uil_field_model (
	// clock
	input  wire logic        aclk,
	// operator commands
	input  wire logic [13:0] close_cmd,
	input  wire logic        key_cmd,
	// device pins
	output var  logic [13:0] contact_in,
	output var  logic        reset_key_in
);
	initial begin
		contact_in = '0;
		reset_key_in = 1'b0;
	end
	// contacts bounce-free but move after the edge, never in step with sampling
	always @(posedge aclk) begin
		contact_in   <= #1 close_cmd;
		reset_key_in <= #1 key_cmd;
	end
endmodule
`default_nettype wire

/* File: sim/uil_top_bench.sv */
// self-checking bench for the user input logic block
`timescale 1ns/10ps
`default_nettype none
module uil_top_bench;
	// ==========================================================
	// signals
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, key_cmd = 0;
	logic [31:0] wdata = '0, d;
	logic [3:0] wstrb = 4'hf;
	logic [13:0] close_cmd = '0, contact_in;
	logic awready, wready, bvalid, arready, rvalid, irq, reset_key_in;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata;
	logic [19:0] diag_msg;
	uil_pkg::uil_out_type outs;
	int bad_count = 0, n_checks = 0;
	logic [3:0] modes [6] = '{4'h9, 4'ha, 4'hb, 4'h8, 4'h4, 4'h3};
	// expected assertion indexed by {closed, virtual on}
	logic [3:0] truth [6] = '{4'h9, 4'h9, 4'h6, 4'h6, 4'he, 4'h1};

	always #50 aclk = ~aclk;

	uil_field_model field (.aclk(aclk), .close_cmd(close_cmd), .key_cmd(key_cmd),
		.contact_in(contact_in), .reset_key_in(reset_key_in));
	uil_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.contact_in(contact_in), .reset_key_in(reset_key_in), .outs(outs),
		.diag_msg(diag_msg), .irq(irq));

	// ==========================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		rs = bresp;
		bready <= 1'b0;
		chk("write_wait", 0, n == 50);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		chk("read_wait", 0, n == 50);
	endtask

	// synchroniser, asserted stage and output stage, plus the model's own edge
	task automatic settle;
		repeat (7) @(posedge aclk);
		@(negedge aclk);
	endtask

	task automatic set_in(input logic cl, input logic [19:0] vi);
		@(posedge aclk);
		close_cmd <= {13'h0, cl};
		wr(uil_pkg::ADDR_VIRT, {12'h0, vi}, r);
		settle;
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		stop_test;
	end

	// ==========================================================
	// tests
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(uil_pkg::ADDR_FORCE, d, r);
		chk("force_reset", 32'h0, d);
		rd(uil_pkg::ADDR_CFG_BASE, d, r);
		chk("cfg_reset", 32'hc, d);
		rd(8'h30, d, r);
		chk("rd_unmapped", uil_pkg::RESP_SLVERR, r);
		wr(8'h30, 32'h1, r);
		chk("wr_unmapped", uil_pkg::RESP_SLVERR, r);
		wr(uil_pkg::ADDR_MASK, 32'h1, r);
		for (int m = 0; m < 6; m++) begin
			wr(uil_pkg::ADDR_CFG_BASE, {26'h1, modes[m]}, r);
			for (int k = 0; k < 4; k++) begin
				set_in(k[1], {19'h0, k[0]});
				chk("alarm_outs", {4{truth[m][k]}},
					{outs.relay[2], outs.aux_led,
					outs.alarm_led, diag_msg[0]});
			end
		end
		// event record and interrupt, mode closed-or-von
		wr(uil_pkg::ADDR_CFG_BASE, 32'h14, r);
		set_in(0, 20'h0);
		rd(uil_pkg::ADDR_STATUS, d, r);
		set_in(0, 20'h1);
		chk("irq_set", 1, irq);
		rd(uil_pkg::ADDR_STATUS, d, r);
		chk("status_event", 1, d[0]);
		settle;
		chk("irq_clear", 0, irq);
		wr(uil_pkg::ADDR_MASK, 32'h0, r);
		set_in(0, 20'h0);
		set_in(0, 20'h1);
		chk("irq_masked", 0, irq);
		wr(uil_pkg::ADDR_CFG_BASE, 32'h24, r);
		settle;
		chk("control_outs", 4'hc,
			{outs.relay[2], outs.aux_led, outs.alarm_led, diag_msg[0]});
		wr(uil_pkg::ADDR_CFG_BASE, 32'h34, r);
		settle;
		chk("trip_outs", 6'h3f, {outs.relay[0], outs.trip_led, outs.relay[2],
			outs.aux_led, diag_msg[0], outs.ssr_on});
		set_in(0, 20'h0);
		chk("trip_held", 3'h3, {outs.relay[0], outs.trip_led, diag_msg[0]});
		wr(uil_pkg::ADDR_CTRL, 32'h1, r);
		settle;
		chk("trip_clear", 2'h0, {outs.trip_led, diag_msg[0]});
		set_in(0, 20'h1);
		set_in(0, 20'h0);
		@(posedge aclk);
		key_cmd <= 1'b1;
		settle;
		@(posedge aclk);
		key_cmd <= 1'b0;
		settle;
		chk("key_clear", 2'h0, {outs.trip_led, diag_msg[0]});
		wr(uil_pkg::ADDR_CFG_BASE, 32'hc, r);
		for (int k = 0; k < 4; k++) begin
			wr(8'h78, k[1] ? 32'h19 : 32'h18, r);
			set_in(0, {5'h0, k[0], 14'h0});
			rd(uil_pkg::ADDR_ASSERTED, d, r);
			chk("virtual_only", k[0] ^ k[1], d[14]);
		end
		wr(8'h78, 32'hc, r);
		wr(uil_pkg::ADDR_FORCE, 32'h1, r);
		settle;
		chk("force_all_off", 9'h0, {outs.relay, outs.ssr_on});
		for (int i = 0; i < 8; i++) begin
			wr(uil_pkg::ADDR_FORCE, 32'h1 | (32'h2 << i), r);
			settle;
			chk("force_relay", {8'h1 << i, i == 0}, {outs.relay, outs.trip_led});
		end
		wr(uil_pkg::ADDR_FORCE, 32'h201, r);
		settle;
		chk("force_ssr_on", 1, outs.ssr_on);
		wr(uil_pkg::ADDR_FORCE, 32'h001, r);
		settle;
		chk("force_ssr_off", 0, outs.ssr_on);
		wr(uil_pkg::ADDR_FORCE, 32'h3ff, r);
		wr(uil_pkg::ADDR_FORCE, 32'h3fe, r);
		settle;
		chk("force_off_normal", 9'h100, {outs.relay, outs.ssr_on});
		wr(uil_pkg::ADDR_CTRL, 32'h2, r);
		settle;
		chk("close_relay", 8'h82, outs.relay);
		stop_test;
	end
endmodule
`default_nettype wire
